// *** verilog/bsic_consts.vh ***
/*
 * Constants for the boundary-scan instruction chain: instruction codes,
 * identification fields, chain layout and FIFO sizing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef BSIC_CONSTS_VH
`define BSIC_CONSTS_VH

`define BSIC_IR_W 4
`define BSIC_OP_EXTEST 4'h0
`define BSIC_OP_IDCODE 4'h1
`define BSIC_OP_SAMPLE 4'h2
`define BSIC_OP_RESET 4'hC
`define BSIC_OP_BYPASS 4'hF
`define BSIC_ID_VER_LSB 28
`define BSIC_ID_PART_LSB 12
`define BSIC_ID_MFR_LSB 1
`define BSIC_NPINS 8
`define BSIC_NOSC 5
`define BSIC_FIFO_DEPTH 32
`define BSIC_FIFO_AW 5
`define BSIC_IR_CAPTURE 4'h1

`endif

// *** verilog/bsic_top.v ***
/*
 * Boundary-scan instruction chain and its FIFO, oversampling TCK on MCLK.
 * Assumes an external scan controller drives TCK, TMS and TDI as pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bsic_consts.vh"

module bsic_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = `BSIC_FIFO_DEPTH,
  parameter AW = `BSIC_FIFO_AW
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg vld_r;
  wire push;
  wire pop;
  wire load;
  wire [AW:0] occ;

  // Output stage holds the head word; it counts toward the depth so that
  // no more than DEPTH words are ever held and the full flag is not late
  assign occ = cnt_r + {{AW{1'b0}}, vld_r};
  assign in_ready = (occ != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign out_valid = vld_r;
  assign pop = (cnt_r != {(AW+1){1'b0}}) && (!vld_r || out_ready);
  assign load = pop;

  // Storage, pointers and fill count
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      vld_r <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (load) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
        out_data <= mem_r[rp_r];
        vld_r <= 1'b1;
      end else if (out_ready) begin
        vld_r <= 1'b0;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end
endmodule // bsic_fifo

module bsic_top #(
  parameter NPINS = `BSIC_NPINS,
  parameter [3:0] ID_VERSION = 4'h0,     // Arbitrary value
  parameter [15:0] ID_PART = 16'h1234,   // Arbitrary value
  parameter [10:0] ID_MFR = 11'h055      // Arbitrary value
) (
  input wire MCLK,
  input wire RST,
  input wire TCK,
  input wire TMS,
  input wire TDI,
  output reg TDO,
  output reg TDO_OE,
  output wire TDO_VALID,
  input wire TDO_READY,
  input wire [NPINS-1:0] PIN_LEVEL,
  input wire [NPINS-1:0] PORT_OUTPUT_BIT,
  input wire [NPINS-1:0] DIRECTION_BIT,
  input wire GLOBAL_PULLUP_DISABLE,
  output wire [NPINS-1:0] PIN_OUT,
  output wire [NPINS-1:0] PIN_OE,
  output wire [NPINS-1:0] PIN_PULLUP_EN,
  output wire [1:0] TWO_WIRE_DRIVER_ENABLE,
  input wire NORMAL_RESET_OBSERVE,
  input wire HIGH_VOLTAGE_RESET_OBSERVE,
  input wire [`BSIC_NOSC-1:0] OSC_ENABLE_SYS,
  input wire [`BSIC_NOSC-1:0] OSC_CLOCK,
  input wire [`BSIC_NOSC-1:0] OSC_OPTION_USED,
  output wire [`BSIC_NOSC-1:0] OSC_ENABLE,
  output wire CORE_RESET,
  output wire [3:0] INSTR
);
  // Chain: per pin pull-up, ctl, data; two-wire en x2; reset obs x2; osc en+clk
  localparam CHAIN = 3 * NPINS + 2 + 2 + 2 * `BSIC_NOSC;
  localparam OSC_B = 3 * NPINS + 4;
  // Oscillator order: ext clock, crystal, ext RC, low freq, timer
  localparam [`BSIC_NOSC-1:0] OSC_IDLE = 5'h04;
  localparam S_RESET = 4'h0, S_IDLE = 4'h1, S_SELDR = 4'h2, S_CAPDR = 4'h3;
  localparam S_SHDR = 4'h4, S_EX1DR = 4'h5, S_PAUDR = 4'h6, S_EX2DR = 4'h7;
  localparam S_UPDR = 4'h8, S_SELIR = 4'h9, S_CAPIR = 4'hA, S_SHIR = 4'hB;
  localparam S_EX1IR = 4'hC, S_PAUIR = 4'hD, S_EX2IR = 4'hE, S_UPIR = 4'hF;

  reg [2:0] tck_s_r;
  reg tms_m_r, tms_s_r, tdi_m_r, tdi_s_r;
  reg [NPINS-1:0] pin_m_r, pin_s_r;
  reg [`BSIC_NOSC-1:0] osc_m_r, osc_s_r;
  reg [1:0] rsto_m_r, rsto_s_r;
  reg [3:0] st_r;
  reg [3:0] ir_sh_r, ir_r;
  reg [31:0] id_r;
  reg byp_r;
  reg rst_reg_r;
  reg [CHAIN-1:0] bs_sh_r, bs_up_r;
  reg tdo_nxt;
  wire rise, fall;
  wire [CHAIN-1:0] bs_cap;
  wire extest;
  wire [1:0] fifo_dummy;
  genvar g;

  // Decodes instruction to data register; unknown codes mean bypass
  function [1:0] dr_sel;
    input [3:0] op;
    begin
      case (op)
        `BSIC_OP_EXTEST, `BSIC_OP_SAMPLE: dr_sel = 2'h1;
        `BSIC_OP_IDCODE: dr_sel = 2'h2;
        `BSIC_OP_RESET: dr_sel = 2'h3;
        default: dr_sel = 2'h0;
      endcase
    end
  endfunction

  // Two-stage synchronisers on TCK, TMS and TDI, then TCK edge detection
  always @(posedge MCLK) begin
    if (RST) begin
      tck_s_r <= 3'h0;
      tms_m_r <= 1'b0;
      tms_s_r <= 1'b0;
      tdi_m_r <= 1'b0;
      tdi_s_r <= 1'b0;
    end else begin
      // Third stage only delays TCK so that its edges can be found
      tck_s_r <= {tck_s_r[1:0], TCK};
      tms_m_r <= TMS;
      tms_s_r <= tms_m_r;
      tdi_m_r <= TDI;
      tdi_s_r <= tdi_m_r;
    end
  end
  assign rise = tck_s_r[1] && !tck_s_r[2];
  assign fall = !tck_s_r[1] && tck_s_r[2];

  // Pin, reset-pin and oscillator observe paths; only a metastability guard.
  // Oscillator clocks run free of MCLK, so an observed clock bit is a
  // snapshot and may differ from scan to scan.
  always @(posedge MCLK) begin
    pin_m_r <= PIN_LEVEL;
    pin_s_r <= pin_m_r;
    osc_m_r <= OSC_CLOCK;
    osc_s_r <= osc_m_r;
    rsto_m_r <= {HIGH_VOLTAGE_RESET_OBSERVE, NORMAL_RESET_OBSERVE};
    rsto_s_r <= rsto_m_r;
  end

  // TAP state machine, reset only by RST or TMS, never by core reset
  // TMS is taken on the MCLK edge that sees the TCK rise, aligned by its synchroniser
  // TAP independent of core reset
  always @(posedge MCLK) begin
    if (RST) begin
      st_r <= S_RESET;
    end else if (rise) begin
      case (st_r)
        S_RESET: st_r <= tms_s_r ? S_RESET : S_IDLE;
        S_IDLE: st_r <= tms_s_r ? S_SELDR : S_IDLE;
        S_SELDR: st_r <= tms_s_r ? S_SELIR : S_CAPDR;
        S_CAPDR: st_r <= tms_s_r ? S_EX1DR : S_SHDR;
        S_SHDR: st_r <= tms_s_r ? S_EX1DR : S_SHDR;
        S_EX1DR: st_r <= tms_s_r ? S_UPDR : S_PAUDR;
        S_PAUDR: st_r <= tms_s_r ? S_EX2DR : S_PAUDR;
        S_EX2DR: st_r <= tms_s_r ? S_UPDR : S_SHDR;
        S_UPDR: st_r <= tms_s_r ? S_SELDR : S_IDLE;
        S_SELIR: st_r <= tms_s_r ? S_RESET : S_CAPIR;
        S_CAPIR: st_r <= tms_s_r ? S_EX1IR : S_SHIR;
        S_SHIR: st_r <= tms_s_r ? S_EX1IR : S_SHIR;
        S_EX1IR: st_r <= tms_s_r ? S_UPIR : S_PAUIR;
        S_PAUIR: st_r <= tms_s_r ? S_EX2IR : S_PAUIR;
        S_EX2IR: st_r <= tms_s_r ? S_UPIR : S_SHIR;
        S_UPIR: st_r <= tms_s_r ? S_SELDR : S_IDLE;
        default: st_r <= S_RESET;
      endcase
    end
  end

  // Instruction register, four bits, LSB first
  // four-bit instruction
  always @(posedge MCLK) begin
    if (RST) begin
      ir_sh_r <= `BSIC_IR_CAPTURE;
      ir_r <= `BSIC_OP_IDCODE;
    end else if (rise) begin
      if (st_r == S_RESET) begin
        ir_r <= `BSIC_OP_IDCODE;
      end else if (st_r == S_CAPIR) begin
        ir_sh_r <= `BSIC_IR_CAPTURE;
      end else if (st_r == S_SHIR) begin
        ir_sh_r <= {tdi_s_r, ir_sh_r[3:1]};
      end
    // New instruction takes effect on the TCK fall in Update-IR
    end else if (fall && st_r == S_UPIR) begin
      ir_r <= ir_sh_r;
    end
  end
  assign INSTR = ir_r;

  // Capture vector: pin cells, two-wire enables, reset and clock observes
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pin
      assign bs_cap[3*g] = !GLOBAL_PULLUP_DISABLE && !DIRECTION_BIT[g] &&
        PORT_OUTPUT_BIT[g];
      assign bs_cap[3*g+1] = DIRECTION_BIT[g];
      assign bs_cap[3*g+2] = pin_s_r[g];
    end
    for (g = 0; g < `BSIC_NOSC; g = g + 1) begin : g_osc
      assign bs_cap[OSC_B+2*g] = OSC_ENABLE_SYS[g];
      assign bs_cap[OSC_B+2*g+1] = OSC_OPTION_USED[g] ? osc_s_r[g] : OSC_IDLE[g];
    end
  endgenerate
  assign bs_cap[3*NPINS+1:3*NPINS] = 2'h0;
  assign bs_cap[3*NPINS+2] = rsto_s_r[0];
  assign bs_cap[3*NPINS+3] = rsto_s_r[1];

  // Data registers: capture, shift, update
  always @(posedge MCLK) begin
    if (RST) begin
      id_r <= 32'h00000000;
      byp_r <= 1'b0;
      rst_reg_r <= 1'b0;
      bs_sh_r <= {CHAIN{1'b0}};
      bs_up_r <= {CHAIN{1'b0}};
    end else if (rise && st_r == S_CAPDR) begin
      id_r <= {ID_VERSION, ID_PART, ID_MFR, 1'b1};
      byp_r <= 1'b0;
      if (dr_sel(ir_r) == 2'h1) begin
        bs_sh_r <= bs_cap;
      end
    end else if (rise && st_r == S_SHDR) begin
      case (dr_sel(ir_r))
        2'h1: bs_sh_r <= {tdi_s_r, bs_sh_r[CHAIN-1:1]};
        2'h2: id_r <= {tdi_s_r, id_r[31:1]};
        // No update latch here, so core reset moves with each shift
        // reset register shift
        2'h3: rst_reg_r <= tdi_s_r;
        default: byp_r <= tdi_s_r;
      endcase
    end else if (fall && st_r == S_UPDR && dr_sel(ir_r) == 2'h1) begin
      bs_up_r <= bs_sh_r;
    end
  end

  assign CORE_RESET = rst_reg_r;

  // Pins follow the latches as soon as the instruction lands; preload first
  // chain select under external test
  assign extest = (ir_r == `BSIC_OP_EXTEST);
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_drv
      assign PIN_PULLUP_EN[g] = extest ? bs_up_r[3*g] : 1'b0;
      assign PIN_OE[g] = extest ? bs_up_r[3*g+1] : 1'b0;
      assign PIN_OUT[g] = extest ? bs_up_r[3*g+2] : 1'b0;
    end
    for (g = 0; g < `BSIC_NOSC; g = g + 1) begin : g_oen
      assign OSC_ENABLE[g] = extest ? bs_up_r[OSC_B+2*g] : OSC_ENABLE_SYS[g];
    end
  endgenerate
  assign TWO_WIRE_DRIVER_ENABLE = extest ? bs_up_r[3*NPINS+1:3*NPINS] : 2'h0;

  // TDO source and enable, updated on TCK falling edge
  // A fall launch leaves half a TCK period before the controller samples
  // unknown codes to bypass
  always @* begin
    case (dr_sel(ir_r))
      2'h1: tdo_nxt = bs_sh_r[0];
      2'h2: tdo_nxt = id_r[0];
      2'h3: tdo_nxt = rst_reg_r;
      default: tdo_nxt = byp_r;
    endcase
    if (st_r == S_SHIR) begin
      tdo_nxt = ir_sh_r[0];
    end
  end
  always @(posedge MCLK) begin
    if (RST) begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (fall) begin
      TDO <= tdo_nxt;
      TDO_OE <= (st_r == S_SHDR) || (st_r == S_SHIR);
    end
  end

  // Stream of shifted-out bits, one per TCK rise in a shift state
  // Words arriving while full are dropped; shifting never waits on the log
  bsic_fifo #(.WIDTH(2), .DEPTH(`BSIC_FIFO_DEPTH), .AW(`BSIC_FIFO_AW)) u_fifo (
    .clk(MCLK),
    .rst(RST),
    .in_valid(rise && TDO_OE),
    .in_ready(),
    .in_data({st_r == S_SHIR, TDO}),
    .out_valid(TDO_VALID),
    .out_ready(TDO_READY),
    .out_data(fifo_dummy)
  );
endmodule // bsic_top
`default_nettype wire

// *** verification/bsic_chk_sva.sv ***
/* Checker: port-level assertions on bsic_top.
   Assumes a bind into bsic_top, one MCLK domain, RST synchronous. */
`timescale 1ns/1ps
`default_nettype none
module bsic_chk_sva #(parameter int NPINS = 8) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic TDO_OE,
  input wire logic TDO_VALID,
  input wire logic TDO_READY,
  input wire logic [NPINS-1:0] PIN_OUT,
  input wire logic [NPINS-1:0] PIN_OE,
  input wire logic [NPINS-1:0] PIN_PULLUP_EN,
  input wire logic [1:0] TWO_WIRE_DRIVER_ENABLE,
  input wire logic [4:0] OSC_ENABLE_SYS,
  input wire logic [4:0] OSC_ENABLE,
  input wire logic CORE_RESET,
  input wire logic [3:0] INSTR
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // Instruction, pin and core reset relations
  a_reset_ir: assert property ($fell(RST) |-> INSTR == 4'h1)
    else $error("instruction not identification after reset");
  a_pins_quiet: assert property ((INSTR != 4'h0)[*2] |-> PIN_OE == '0 && PIN_OUT == '0
    && PIN_PULLUP_EN == '0 && TWO_WIRE_DRIVER_ENABLE == 2'h0)
    else $error("pins driven outside external test");
  a_osc_pass: assert property ((INSTR != 4'h0)[*2] |-> OSC_ENABLE == OSC_ENABLE_SYS)
    else $error("oscillator enable not from system");
  a_ir_quiet: assert property ($changed(INSTR) |-> !TDO_OE)
    else $error("instruction changed while shifting");
  a_core_instr: assert property ($changed(CORE_RESET) |-> INSTR == 4'hC)
    else $error("core reset moved under other instruction");
  a_core_shift: assert property ($changed(CORE_RESET) |-> TDO_OE || $past(TDO_OE))
    else $error("core reset moved outside shift");
  a_core_hold: assert property (CORE_RESET && !TDO_OE |=> CORE_RESET)
    else $error("core reset dropped while register holds one");
  a_ext_hold: assert property (INSTR == 4'h0 && $past(INSTR) == 4'h0
    && $changed(PIN_OUT) |-> !TDO_OE)
    else $error("pin outputs changed during shift");
  // Main scenarios reached
  c_ext_drive: cover property (INSTR == 4'h0 && PIN_OE != '0);
  c_core_reset: cover property (CORE_RESET);
  c_fifo_pop: cover property (TDO_VALID && TDO_READY);
endmodule // bsic_chk_sva
bind bsic_top bsic_chk_sva #(.NPINS(NPINS)) u_bsic_chk_sva (.MCLK(MCLK), .RST(RST),
  .TDO_OE(TDO_OE), .TDO_VALID(TDO_VALID), .TDO_READY(TDO_READY), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE), .PIN_PULLUP_EN(PIN_PULLUP_EN), .TWO_WIRE_DRIVER_ENABLE(TWO_WIRE_DRIVER_ENABLE),
  .OSC_ENABLE_SYS(OSC_ENABLE_SYS), .OSC_ENABLE(OSC_ENABLE), .CORE_RESET(CORE_RESET),
  .INSTR(INSTR));
`default_nettype wire

// *** verification/bsic_jtag_ctl.sv ***
/* Scan controller model: drives TCK, TMS, TDI and reads TDO.
   Assumes the TAP starts in reset or idle and one caller at a time. */
`timescale 1ns/1ps
`default_nettype none
module bsic_jtag_ctl (
  output logic TCK,
  output logic TMS,
  output logic TDI,
  input wire logic TDO
);
  logic unused;
  // Idle levels, TCK stands low between scans
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end
  // One 32 ns TCK period, TDO read late in the high phase
  task step(input logic ms, input logic di, output logic dout);
    TMS = ms;
    TDI = di;
    #16 TCK = 1'b1;
    #12 dout = TDO;
    #4 TCK = 1'b0;
  endtask
  // State move only, TDI toggles as it carries no data
  task move(input logic ms);
    step(ms, ~TDI, unused);
  endtask
  task scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    move(1'b0);
    move(1'b1);
    if (ir) move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    move(1'b1);
    move(1'b0);
  endtask
endmodule // bsic_jtag_ctl
`default_nettype wire

// *** verification/tb.sv ***
/* Bench for bsic_top: scans through the controller model, pin and clock
   inputs, FIFO drain. Assumes the model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "bsic_consts.vh"
module tb;
  localparam int NP = 2;
  localparam logic [3:0] IDV = 4'h3; // Arbitrary value
  localparam logic [15:0] IDP = 16'hC35A; // Arbitrary value
  localparam logic [10:0] IDM = 11'h2A6; // Arbitrary value
  localparam logic [63:0] PAT_A = 64'h1015;
  localparam logic [63:0] PAT_B = 64'h100E8;
  localparam logic [19:0] CMASK = 20'hFFFFF;
  logic MCLK, RST, TDO_READY, GLOBAL_PULLUP_DISABLE;
  logic NORMAL_RESET_OBSERVE, HIGH_VOLTAGE_RESET_OBSERVE;
  logic [NP-1:0] PIN_LEVEL, PORT_OUTPUT_BIT, DIRECTION_BIT;
  logic [4:0] OSC_CLOCK, OSC_OPTION_USED;
  wire TCK, TMS, TDI, TDO, TDO_OE, TDO_VALID, CORE_RESET;
  wire [NP-1:0] PIN_OUT, PIN_OE, PIN_PULLUP_EN;
  wire [1:0] TWO_WIRE_DRIVER_ENABLE;
  wire [4:0] OSC_ENABLE;
  wire [3:0] INSTR;
  logic [63:0] q;
  logic [3:0] codes [3] = '{`BSIC_OP_BYPASS, 4'h5, 4'h9};
  int bad_count = 0, checks = 0, cyc = 0, n;

  bsic_top #(.NPINS(NP), .ID_VERSION(IDV), .ID_PART(IDP), .ID_MFR(IDM)) u_bsic_top (
    .MCLK(MCLK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE),
    .TDO_VALID(TDO_VALID), .TDO_READY(TDO_READY), .PIN_LEVEL(PIN_LEVEL),
    .PORT_OUTPUT_BIT(PORT_OUTPUT_BIT), .DIRECTION_BIT(DIRECTION_BIT),
    .GLOBAL_PULLUP_DISABLE(GLOBAL_PULLUP_DISABLE), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
    .PIN_PULLUP_EN(PIN_PULLUP_EN), .TWO_WIRE_DRIVER_ENABLE(TWO_WIRE_DRIVER_ENABLE),
    .NORMAL_RESET_OBSERVE(NORMAL_RESET_OBSERVE),
    .HIGH_VOLTAGE_RESET_OBSERVE(HIGH_VOLTAGE_RESET_OBSERVE), .OSC_ENABLE_SYS(5'h02),
    .OSC_CLOCK(OSC_CLOCK), .OSC_OPTION_USED(OSC_OPTION_USED), .OSC_ENABLE(OSC_ENABLE),
    .CORE_RESET(CORE_RESET), .INSTR(INSTR));
  bsic_jtag_ctl u_bsic_jtag_ctl (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO));

  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task ir(input logic [3:0] c);
    #1 u_bsic_jtag_ctl.scan(1'b1, 4, {60'h0, c}, q);
    repeat (8) @(posedge MCLK);
    chk(q[3:0], `BSIC_IR_CAPTURE);
    chk(INSTR, c);
  endtask
  task dr(input int len, input logic [63:0] d);
    #1 u_bsic_jtag_ctl.scan(1'b0, len, d, q);
    repeat (8) @(posedge MCLK);
  endtask
  task setin(input logic [18:0] v);
    @(posedge MCLK);
    #1 {PIN_LEVEL, PORT_OUTPUT_BIT, DIRECTION_BIT, GLOBAL_PULLUP_DISABLE, NORMAL_RESET_OBSERVE,
      HIGH_VOLTAGE_RESET_OBSERVE, OSC_CLOCK, OSC_OPTION_USED} = v;
    repeat (4) @(posedge MCLK);
  endtask
  task outs(input logic [63:0] p);
    chk({OSC_ENABLE, TWO_WIRE_DRIVER_ENABLE, PIN_PULLUP_EN, PIN_OE, PIN_OUT}, {p[18], p[16],
      p[14], p[12], p[10], p[7:6], p[3], p[0], p[4], p[1], p[5], p[2]});
  endtask

  // 250 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  // Cut a hang short
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    RST = 1'b1;
    TDO_READY = 1'b0;
    {PIN_LEVEL, PORT_OUTPUT_BIT, DIRECTION_BIT, GLOBAL_PULLUP_DISABLE, NORMAL_RESET_OBSERVE,
      HIGH_VOLTAGE_RESET_OBSERVE, OSC_CLOCK, OSC_OPTION_USED} = 19'h0;
    repeat (12) @(posedge MCLK);
    #1 RST = 1'b0;
    repeat (3) @(posedge MCLK);
    chk(INSTR, `BSIC_OP_IDCODE);
    dr(32, 64'h0);
    chk(q[31:0], {IDV, IDP, IDM, 1'b1});
    for (int k = 0; k < 3; k++) begin
      ir(codes[k]);
      dr(8, 64'hB3);
      chk(q[7:0], 8'h66);
    end
    chk(TDO_VALID, 1'b1);
    @(posedge MCLK);
    #1 TDO_READY = 1'b1;
    n = 0;
    // Each sample stands 3 ns before the edge that takes the word
    repeat (40) begin
      n += TDO_VALID;
      @(posedge MCLK);
      #1;
    end
    chk(n, `BSIC_FIFO_DEPTH);
    chk(TDO_VALID, 1'b0);
    ir(`BSIC_OP_RESET);
    dr(1, 64'h1);
    chk(CORE_RESET, 1'b1);
    ir(`BSIC_OP_BYPASS);
    chk(CORE_RESET, 1'b1);
    ir(`BSIC_OP_RESET);
    dr(1, 64'h0);
    chk(q[0], 1'b1);
    chk(CORE_RESET, 1'b0);
    setin(19'h48AA0);
    ir(`BSIC_OP_SAMPLE);
    dr(20, PAT_A);
    chk(q[19:0] & CMASK, 20'h09121);
    chk({PIN_OUT, PIN_OE, PIN_PULLUP_EN, TWO_WIRE_DRIVER_ENABLE}, 8'h00);
    chk(OSC_ENABLE, 5'h02);
    ir(`BSIC_OP_EXTEST);
    outs(PAT_A);
    setin(19'h3D55F);
    dr(20, PAT_B);
    chk(q[19:0] & CMASK, 20'h23214);
    outs(PAT_B);
    summarize();
  end
endmodule // tb
`default_nettype wire
